// *** fsl_pkg.sv ***
// Purpose: Shared constants, types and code tables for the 100 Mb/s line coding path.
// Assumes: One line bit per mclk_i edge; symbols go out most significant bit first.
// Notes:
// Operation
// (RQ1) Map nibbles to code groups and back
// (RQ2) Six control groups, ten invalid groups
// (RQ3) H error, I idle, J-K start, T-R end
// (RQ4) Undefined group sets invalid-symbol flag
// (RQ5) Halt group sets halt-symbol flag
// (RQ6) Invalid-codes enable plus error sends invalid groups
// (RQ7) Scramble transmit, descramble receive
// (RQ8) Symbol interface bypasses scrambler and descrambler
// (RQ9) MLT-3 transmit with levels plus, zero, minus
// (RQ10) MLT-3 receive decode back to NRZI
// (RQ11) Auto polarity correction unless inhibit set
// (RQ12) Polarity judged from normal link pulses
// (RQ13) Reversed polarity inverts data, sets flag
// (RQ14) Polarity-reversed flag latches high
// (RQ15) Polarity correction active during auto-negotiation
// (RQ16) J-K replaces preamble start, T-R appended; a one-nibble frame ends J-K-R with no T
// (RQ17) Start delimiter becomes two preamble nibbles
// (RQ18) Standard 4B/5B code table used exactly
// (RQ19) Sticky flags clear on read unless cause persists
package fsl_pkg;

  // Control code groups
  localparam logic [4:0] SYM_I = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_H = 5'h04;
  // Group sent for a forced error when invalid codes are enabled (undefined group)
  localparam logic [4:0] SYM_BAD = 5'h01;

  // Symbol framing
  localparam logic [2:0] SYM_LAST = 3'h4;
  localparam logic [9:0] SSD_PAIR = {SYM_J, SYM_K};
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;

  // Descrambler lock length, one full LFSR fill
  localparam logic [3:0] LOCK_BITS = 4'hB;

  // Line levels
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_POS = 2'h1;
  localparam logic [1:0] LVL_NEG = 2'h3;

  // Transmit sequencer states
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_KSYM = 4'h2,
    TX_DATA = 4'h4,
    TX_RSYM = 4'h8
  } fsl_tx_state_e;

  // Nibble carriers toward and from the MAC side
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] data;
  } fsl_txnib_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] data;
  } fsl_rxnib_s;

  // Nibble to data code group
  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] s;
    s = SYM_I;
    unique case (n)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
    endcase
    return s;
  endfunction

  // Code group to {is_data, nibble}; non-data groups give is_data low
  function automatic logic [4:0] dec5b4b(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    case (s)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

endpackage

// *** fsl_lfsr.sv ***
// Purpose: Eleven-stage stream cipher for scrambling or descrambling one bit per clock.
// Assumes: Key polynomial x^11 + x^9 + 1.
// Notes: load_i seeds the register from the line so a descrambler can lock on idle.
`timescale 1ns/100ps
`default_nettype none
module fsl_lfsr (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Seeding
  input wire logic load_i,
  input wire logic load_bit_i,
  // Bit stream
  input wire logic data_i,
  output logic data_o
);

  logic [10:0] key_reg; // Cipher state
  logic key_bit; // Current key stream bit

  assign key_bit = key_reg[10] ^ key_reg[8];
  assign data_o = data_i ^ key_bit; // [RQ7]

  // Advance the key; while seeding, shift in the recovered key bit instead
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_reg <= 11'h7FF;
    end else if (load_i) begin
      key_reg <= {key_reg[9:0], load_bit_i};
    end else begin
      key_reg <= {key_reg[9:0], key_bit};
    end
  end

endmodule
`default_nettype wire

// *** fsl_line_coding.sv ***
// Purpose: 4B/5B coding, scrambling, NRZI and MLT-3 with receive polarity correction.
// Assumes: One line bit per mclk_i edge in both directions; idle plaintext is all ones.
// Notes: Nibbles move one per five clocks; the MAC side must follow the take strobe.
`timescale 1ns/100ps
`default_nettype none
module fsl_line_coding (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Configuration
  input wire logic sym_mode_i,
  input wire logic tx_inv_en_i,
  input wire logic pol_inhibit_i,
  // Transmit nibbles
  input wire fsl_pkg::fsl_txnib_s tx_nib_i,
  output logic tx_take_o,
  // Receive nibbles
  output fsl_pkg::fsl_rxnib_s rx_nib_o,
  // Line
  output logic [1:0] tx_line_o,
  input wire logic [1:0] rx_line_i,
  // Normal link pulse observations
  input wire logic nlp_stb_i,
  input wire logic nlp_neg_i,
  // Status
  input wire logic stat_rd_i,
  output logic inv_sym_flag_o,
  output logic halt_flag_o,
  output logic pol_rev_flag_o,
  output logic pol_inv_o
);

  // Transmit side
  fsl_pkg::fsl_tx_state_e tx_state_reg; // Delimiter sequencer
  logic [2:0] tx_bit_reg; // Bit position in symbol
  logic [4:0] tx_sh_reg; // Outgoing symbol
  logic [4:0] tx_sym_next; // Next symbol to load
  logic tx_bound; // Last bit of a symbol
  logic tx_plain; // Bit before scrambling
  logic tx_scr; // Bit after scrambler
  logic tx_bit; // Bit after optional bypass
  logic tx_nrzi_reg; // NRZI level
  logic [1:0] tx_phase_reg; // MLT-3 phase

  // Receive side
  logic [1:0] rx_lvl; // Level after polarity correction
  logic [1:0] rx_lvl_reg; // Previous level
  logic rx_nrzi_reg; // Recovered NRZI level
  logic rx_nrzi_d_reg; // Delayed NRZI level
  logic rx_bit_raw; // NRZI-decoded bit
  logic rx_desc; // Descrambled bit
  logic rx_bit; // Bit after optional bypass
  logic [3:0] lock_cnt_reg; // Descrambler seeding count
  logic rx_locked; // Descrambler in step
  logic [9:0] rx_win_reg; // Last ten bits
  logic [9:0] rx_win; // Window including current bit
  logic rx_frame_reg; // Inside a stream
  logic [2:0] rx_bit_cnt_reg; // Bit position in symbol
  logic rx_tpend_reg; // T seen, R expected
  logic pre2_reg; // Second preamble nibble owed
  logic [4:0] rx_dec; // Decoded group
  logic rx_sym_stb; // Whole symbol present in window
  logic inv_set; // Undefined group seen
  logic halt_set; // Halt group seen
  logic pol_rev_reg; // Last pulse showed reversal

  // Transmit symbol choice and nibble take
  assign tx_bound = (tx_bit_reg == fsl_pkg::SYM_LAST);
  assign tx_take_o = tx_bound && tx_nib_i.en && (tx_state_reg != fsl_pkg::TX_RSYM);

  always_comb begin
    tx_sym_next = fsl_pkg::SYM_I;
    unique case (tx_state_reg)
      fsl_pkg::TX_IDLE: begin
        if (tx_nib_i.en) begin
          tx_sym_next = fsl_pkg::SYM_J; // [RQ16] [RQ3]
        end
      end
      fsl_pkg::TX_KSYM: begin
        tx_sym_next = fsl_pkg::SYM_K; // [RQ16]
      end
      fsl_pkg::TX_DATA: begin
        if (!tx_nib_i.en) begin
          tx_sym_next = fsl_pkg::SYM_T; // [RQ16]
        end else if (tx_nib_i.er && tx_inv_en_i) begin
          tx_sym_next = fsl_pkg::SYM_BAD; // [RQ6]
        end else if (tx_nib_i.er) begin
          tx_sym_next = fsl_pkg::SYM_H; // [RQ3]
        end else begin
          tx_sym_next = fsl_pkg::enc4b5b(tx_nib_i.data); // [RQ1] [RQ18]
        end
      end
      fsl_pkg::TX_RSYM: begin
        tx_sym_next = fsl_pkg::SYM_R; // [RQ16]
      end
    endcase
  end

  // Sequencer steps once per symbol; enable dropping in TX_DATA closes with T-R, in TX_KSYM with K then R and no T
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state_reg <= fsl_pkg::TX_IDLE;
    end else if (tx_bound) begin
      unique case (tx_state_reg)
        fsl_pkg::TX_IDLE: begin
          if (tx_nib_i.en) begin
            tx_state_reg <= fsl_pkg::TX_KSYM;
          end
        end
        fsl_pkg::TX_KSYM: begin
          tx_state_reg <= tx_nib_i.en ? fsl_pkg::TX_DATA : fsl_pkg::TX_RSYM;
        end
        fsl_pkg::TX_DATA: begin
          if (!tx_nib_i.en) begin
            tx_state_reg <= fsl_pkg::TX_RSYM;
          end
        end
        fsl_pkg::TX_RSYM: begin
          tx_state_reg <= fsl_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Serialiser, most significant bit first
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= fsl_pkg::SYM_I;
    end else if (tx_bound) begin
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= tx_sym_next;
    end else begin
      tx_bit_reg <= tx_bit_reg + 3'h1;
      tx_sh_reg <= {tx_sh_reg[3:0], 1'b1};
    end
  end

  assign tx_plain = tx_sh_reg[4];

  fsl_lfsr u_scr (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(1'b0),
    .load_bit_i(1'b0),
    .data_i(tx_plain),
    .data_o(tx_scr)
  );

  assign tx_bit = sym_mode_i ? tx_plain : tx_scr; // [RQ8] [RQ7]

  // NRZI toggles on a one; MLT-3 steps 0,+1,0,-1 on each NRZI transition
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_nrzi_reg <= 1'b0;
      tx_phase_reg <= 2'h0;
    end else if (tx_bit) begin
      tx_nrzi_reg <= ~tx_nrzi_reg;
      tx_phase_reg <= tx_phase_reg + 2'h1; // [RQ9]
    end
  end

  // Registered line level so the driver sees no decode glitches
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_line_o <= fsl_pkg::LVL_ZERO;
    end else begin
      unique case (tx_phase_reg)
        2'h1: tx_line_o <= fsl_pkg::LVL_POS; // [RQ9]
        2'h3: tx_line_o <= fsl_pkg::LVL_NEG; // [RQ9]
        default: tx_line_o <= fsl_pkg::LVL_ZERO;
      endcase
    end
  end

  // Polarity from link pulses; kept running in every mode, negotiation included
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pol_rev_reg <= 1'b0;
    end else if (nlp_stb_i) begin
      pol_rev_reg <= nlp_neg_i; // [RQ12] [RQ15]
    end
  end

  assign pol_inv_o = pol_rev_reg && !pol_inhibit_i; // [RQ11]
  // Swap +1 and -1; MLT-3 itself is insensitive but link pulses are not
  assign rx_lvl = pol_inv_o ? (~rx_line_i + 2'h1) : rx_line_i; // [RQ13]

  // MLT-3 decode: any level change is one NRZI transition
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_lvl_reg <= fsl_pkg::LVL_ZERO;
      rx_nrzi_reg <= 1'b0;
      rx_nrzi_d_reg <= 1'b0;
    end else begin
      rx_lvl_reg <= rx_lvl;
      rx_nrzi_reg <= rx_nrzi_reg ^ (rx_lvl != rx_lvl_reg); // [RQ10]
      rx_nrzi_d_reg <= rx_nrzi_reg;
    end
  end

  assign rx_bit_raw = rx_nrzi_reg ^ rx_nrzi_d_reg;
  assign rx_locked = (lock_cnt_reg == fsl_pkg::LOCK_BITS);

  // Seed from idle: with all-ones plaintext the key bit equals the inverted line bit
  fsl_lfsr u_desc (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(!rx_locked),
    .load_bit_i(~rx_bit_raw),
    .data_i(rx_bit_raw),
    .data_o(rx_desc)
  );

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_cnt_reg <= 4'h0;
    end else if (!rx_locked) begin
      lock_cnt_reg <= lock_cnt_reg + 4'h1;
    end
  end

  assign rx_bit = sym_mode_i ? rx_bit_raw : rx_desc; // [RQ8] [RQ7]
  assign rx_win = {rx_win_reg[8:0], rx_bit};
  assign rx_sym_stb = rx_frame_reg && (rx_bit_cnt_reg == fsl_pkg::SYM_LAST);
  assign rx_dec = fsl_pkg::dec5b4b(rx_win[4:0]); // [RQ1] [RQ18]

  // Classify each framed symbol that is the halt group or neither data nor a legal control group
  always_comb begin
    inv_set = 1'b0;
    halt_set = 1'b0;
    if (rx_sym_stb && !rx_dec[4]) begin
      if (rx_win[4:0] == fsl_pkg::SYM_H) begin
        halt_set = 1'b1; // [RQ5]
      end else if (rx_win[4:0] != fsl_pkg::SYM_I && rx_win[4:0] != fsl_pkg::SYM_J &&
                   rx_win[4:0] != fsl_pkg::SYM_K && rx_win[4:0] != fsl_pkg::SYM_T &&
                   rx_win[4:0] != fsl_pkg::SYM_R) begin
        inv_set = 1'b1; // [RQ2] [RQ4]
      end
    end
  end

  // Framing: hunt for J-K, then decode every fifth bit until T-R or idle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_win_reg <= {fsl_pkg::SYM_I, fsl_pkg::SYM_I};
      rx_frame_reg <= 1'b0;
      rx_bit_cnt_reg <= 3'h0;
      rx_tpend_reg <= 1'b0;
      pre2_reg <= 1'b0;
      rx_nib_o <= '0;
    end else begin
      rx_win_reg <= rx_win;
      pre2_reg <= 1'b0;
      rx_nib_o <= '0;
      rx_bit_cnt_reg <= (rx_bit_cnt_reg == fsl_pkg::SYM_LAST) ? 3'h0 : rx_bit_cnt_reg + 3'h1;
      if (pre2_reg) begin
        rx_nib_o <= '{dv: 1'b1, er: 1'b0, data: fsl_pkg::PREAMBLE_NIB}; // [RQ17]
      end
      if (!rx_frame_reg) begin
        if (rx_locked && rx_win == fsl_pkg::SSD_PAIR) begin
          rx_frame_reg <= 1'b1; // [RQ3]
          rx_bit_cnt_reg <= 3'h0;
          rx_tpend_reg <= 1'b0;
          pre2_reg <= 1'b1;
          rx_nib_o <= '{dv: 1'b1, er: 1'b0, data: fsl_pkg::PREAMBLE_NIB}; // [RQ17]
        end
      end else if (rx_sym_stb) begin
        if (rx_tpend_reg) begin
          // End delimiter is swallowed; a broken R is flagged as an error
          rx_frame_reg <= 1'b0; // [RQ17]
          rx_nib_o <= '{dv: 1'b0, er: (rx_win[4:0] != fsl_pkg::SYM_R), data: 4'h0};
        end else if (rx_dec[4]) begin
          rx_nib_o <= '{dv: 1'b1, er: 1'b0, data: rx_dec[3:0]}; // [RQ1]
        end else if (rx_win[4:0] == fsl_pkg::SYM_T) begin
          rx_tpend_reg <= 1'b1; // [RQ3]
        end else if (rx_win[4:0] == fsl_pkg::SYM_I) begin
          rx_frame_reg <= 1'b0; // Premature end
          rx_nib_o <= '{dv: 1'b0, er: 1'b1, data: 4'h0};
        end else begin
          rx_nib_o <= '{dv: 1'b1, er: 1'b1, data: 4'h0}; // Halt, undefined or misplaced J, K or R group
        end
      end
    end
  end

  // Sticky status: a read clears, a same-cycle event wins over the clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inv_sym_flag_o <= 1'b0;
      halt_flag_o <= 1'b0;
      pol_rev_flag_o <= 1'b0;
    end else begin
      inv_sym_flag_o <= inv_set || (inv_sym_flag_o && !stat_rd_i); // [RQ4] [RQ19]
      halt_flag_o <= halt_set || (halt_flag_o && !stat_rd_i); // [RQ5] [RQ19]
      pol_rev_flag_o <= pol_inv_o || (pol_rev_flag_o && !stat_rd_i); // [RQ13] [RQ14] [RQ19]
    end
  end

endmodule
`default_nettype wire

// *** fsl_line_coding_asserts.sv ***
// Purpose: Port-level checks for the line coding block.
// Assumes: One clock domain, reset active low.
// Notes: Watches block inputs and outputs; sticky flags clear one edge after a read.
`timescale 1ns/100ps
`default_nettype none
module fsl_line_coding_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Block inputs
  input wire logic sym_mode_i,
  input wire logic tx_inv_en_i,
  input wire logic pol_inhibit_i,
  input wire fsl_pkg::fsl_txnib_s tx_nib_i,
  input wire logic [1:0] rx_line_i,
  input wire logic nlp_stb_i,
  input wire logic nlp_neg_i,
  input wire logic stat_rd_i,
  // Block outputs
  input wire logic tx_take_o,
  input wire fsl_pkg::fsl_rxnib_s rx_nib_o,
  input wire logic [1:0] tx_line_o,
  input wire logic inv_sym_flag_o,
  input wire logic halt_flag_o,
  input wire logic pol_rev_flag_o,
  input wire logic pol_inv_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Reversed link pulse while correction is allowed
  wire logic rev_seen = nlp_stb_i && nlp_neg_i && !pol_inhibit_i;
  line_levels_a: assert property (tx_line_o != 2'h2)
    else $error("Undefined line level");
  mlt_step_a: assert property (
    tx_line_o == fsl_pkg::LVL_POS |=> tx_line_o != fsl_pkg::LVL_NEG)
    else $error("Line jumped from plus to minus");
  take_space_a: assert property (tx_take_o |=> !tx_take_o [*4])
    else $error("Nibble takes closer than one symbol");
  take_en_a: assert property (tx_take_o |-> tx_nib_i.en)
    else $error("Nibble taken without enable");
  pol_set_a: assert property (rev_seen ##1 !pol_inhibit_i |-> pol_inv_o)
    else $error("Reversed pulse not corrected");
  pol_flag_a: assert property (rev_seen |-> ##[1:2] pol_rev_flag_o)
    else $error("Reversed flag not set");
  pol_inhibit_a: assert property (pol_inhibit_i |-> !pol_inv_o)
    else $error("Correction active while inhibited");
  pol_follow_a: assert property (nlp_stb_i && !nlp_neg_i |=> !pol_inv_o)
    else $error("Normal pulse left correction on");
  pol_latch_a: assert property (pol_rev_flag_o && !stat_rd_i |=> pol_rev_flag_o)
    else $error("Reversed flag dropped without read");
  pol_clear_a: assert property (
    stat_rd_i && !pol_inv_o && !rev_seen |=> !pol_rev_flag_o)
    else $error("Reversed flag kept after read");
  inv_hold_a: assert property (inv_sym_flag_o && !stat_rd_i |=> inv_sym_flag_o)
    else $error("Invalid flag dropped without read");
  // Main scenarios reached
  cover property (tx_take_o);
  cover property ($rose(pol_rev_flag_o));
  cover property ($rose(inv_sym_flag_o));
endmodule
`default_nettype wire

// *** fsl_mac_model.sv ***
// Purpose: MAC-side model handing nibbles to the block on each take strobe.
// Assumes: Two preamble nibbles lead a frame; data is seed xor index.
// Notes: Outside a frame the data lines show the inverse pattern, not a held value.
`timescale 1ns/100ps
`default_nettype none
module fsl_mac_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Frame request
  input wire logic start_i,
  input wire logic [4:0] len_i,
  input wire logic [4:0] er_at_i,
  input wire logic [3:0] seed_i,
  // Nibble handshake
  input wire logic take_i,
  output var fsl_pkg::fsl_txnib_s tx_nib_o
);
  logic busy_reg; // Frame in progress
  logic [4:0] idx_reg; // Nibble index
  logic [3:0] nib; // Current nibble
  // Advance only on a take so each nibble holds until consumed
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      idx_reg <= 5'h00;
    end else if (!busy_reg) begin
      busy_reg <= start_i;
      idx_reg <= 5'h00;
    end else if (take_i) begin
      busy_reg <= (idx_reg != len_i - 5'h01); // Enable drops after last nibble
      idx_reg <= idx_reg + 5'h01;
    end
  end
  // Preamble first; the block swaps it for the start delimiter
  assign nib = (idx_reg < 5'h02) ? fsl_pkg::PREAMBLE_NIB : seed_i ^ idx_reg[3:0];
  // Drive the carrier; error raised on the requested nibble
  always_comb begin
    tx_nib_o.en = busy_reg;
    tx_nib_o.er = busy_reg && (idx_reg == er_at_i);
    tx_nib_o.data = busy_reg ? nib : ~nib;
  end
endmodule
`default_nettype wire

// *** test_fast_ethernet_symbol_line_coding.sv ***
// Purpose: Self-checking bench for the line coding block in loopback.
// Assumes: Transmit line fed back to receive, optionally with crossed pair.
// Notes: Descrambler never relocks, so mode changes go through a reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
  tests_run++; \
  if ((gt) !== (ex)) begin \
    n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); \
  end \
end
module test_fast_ethernet_symbol_line_coding;
  // Clock, reset, configuration
  logic mclk_i, rst_b_i, sym_mode_i, tx_inv_en_i, pol_inhibit_i;
  // Link pulse, status and line crossing
  logic nlp_stb_i, nlp_neg_i, stat_rd_i, swap;
  // Partner controls
  logic start;
  logic [4:0] len, er_at;
  logic [3:0] seed;
  // Design outputs and line
  fsl_pkg::fsl_txnib_s tx_nib_i;
  fsl_pkg::fsl_rxnib_s rx_nib_o;
  logic tx_take_o, inv_sym_flag_o, halt_flag_o, pol_rev_flag_o, pol_inv_o;
  logic [1:0] tx_line_o, rx_line_i;
  int n_errors = 0;
  int tests_run = 0;
  int i, ph;
  // Crossed pair swaps plus and minus, zero stays zero
  assign rx_line_i = {tx_line_o[1] ^ (swap & tx_line_o[0]), tx_line_o[0]};
  fsl_line_coding u_fsl_line_coding (.mclk_i, .rst_b_i, .sym_mode_i, .tx_inv_en_i,
    .pol_inhibit_i, .tx_nib_i, .tx_take_o, .rx_nib_o, .tx_line_o, .rx_line_i,
    .nlp_stb_i, .nlp_neg_i, .stat_rd_i, .inv_sym_flag_o, .halt_flag_o,
    .pol_rev_flag_o, .pol_inv_o);
  fsl_mac_model u_fsl_mac_model (.mclk_i, .rst_b_i, .start_i(start), .len_i(len),
    .er_at_i(er_at), .seed_i(seed), .take_i(tx_take_o), .tx_nib_o(tx_nib_i));
  // Free-running clock, 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // Expected {er, nibble} at position k of a looped frame
  function automatic logic [4:0] exp_nib(input int k, input logic [3:0] s, input int e);
    if (k == e) return 5'h10;
    if (k < 2) return {1'b0, fsl_pkg::PREAMBLE_NIB};
    return {1'b0, s ^ k[3:0]};
  endfunction
  // Verdict and end of run
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Send one frame and collect what comes back; the long window catches extras
  task automatic run_frame(input int n, input int e);
    logic [4:0] q[$];
    int k, nt, nerr;
    seed = 4'($urandom);
    nt = 0;
    nerr = 0;
    len = n[4:0];
    er_at = e[4:0];
    start = 1'b1;
    @(negedge mclk_i);
    start = 1'b0;
    for (k = 0; k < n * 5 + 120; k++) begin
      if (rx_nib_o.dv === 1'b1) q.push_back({rx_nib_o.er, rx_nib_o.data});
      // A clean end delimiter must close the frame without an error pulse
      if (rx_nib_o.dv !== 1'b1 && rx_nib_o.er !== 1'b0) nerr++;
      if (tx_take_o === 1'b1) nt++;
      @(negedge mclk_i);
    end
    `CHK("nibbles taken", n, nt)
    `CHK("stray rx error", 0, nerr)
    `CHK("frame length", n, q.size())
    for (k = 0; k < q.size(); k++) `CHK("rx nibble", exp_nib(k, seed, e), q[k])
  endtask
  // Idle ones toggle the line every bit only when unscrambled
  task automatic check_idle(input logic sym);
    int k, n;
    logic [1:0] last;
    n = 0;
    last = tx_line_o;
    for (k = 0; k < 20; k++) begin
      @(negedge mclk_i);
      if (tx_line_o !== last) n++;
      last = tx_line_o;
    end
    `CHK("idle toggling", sym, n == 20)
  endtask
  // Management status read, then let the clear land
  task automatic rd_stat;
    stat_rd_i = 1'b1;
    @(negedge mclk_i);
    stat_rd_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask
  // One observed link pulse of the given polarity
  task automatic nlp(input logic neg);
    nlp_neg_i = neg;
    nlp_stb_i = 1'b1;
    @(negedge mclk_i);
    nlp_stb_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask
  // Main sequence: scrambled phase, symbol-mode phase, then polarity
  initial begin
    rst_b_i = 1'b0;
    {sym_mode_i, tx_inv_en_i, pol_inhibit_i, nlp_stb_i, nlp_neg_i, stat_rd_i} = '0;
    {swap, start, len, er_at, seed} = '0;
    void'($urandom(32'heb24));
    for (ph = 0; ph < 2; ph++) begin
      rst_b_i = 1'b0;
      sym_mode_i = ph[0];
      repeat (12) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (40) @(negedge mclk_i);
      check_idle(ph[0]);
      run_frame(3, 31);
      run_frame(20, 31);
      for (i = 0; i < 4; i++) run_frame(4 + $urandom % 16, 31);
      for (i = 0; i < 2; i++) begin
        tx_inv_en_i = i[0];
        run_frame(8, 2 + $urandom % 6);
        `CHK("invalid flag", i[0], inv_sym_flag_o)
        `CHK("halt flag", !i[0], halt_flag_o)
        rd_stat();
        `CHK("flags after read", 2'h0, {inv_sym_flag_o, halt_flag_o})
      end
      tx_inv_en_i = 1'b0;
    end
    swap = 1'b1;
    nlp(1'b1);
    run_frame(10, 31);
    `CHK("pol inverting", 1'b1, pol_inv_o)
    `CHK("pol flag", 1'b1, pol_rev_flag_o)
    rd_stat();
    `CHK("pol flag held", 1'b1, pol_rev_flag_o)
    pol_inhibit_i = 1'b1;
    @(negedge mclk_i);
    `CHK("pol inhibited", 1'b0, pol_inv_o)
    pol_inhibit_i = 1'b0;
    swap = 1'b0;
    nlp(1'b0);
    `CHK("pol flag latched", 1'b1, pol_rev_flag_o)
    rd_stat();
    `CHK("pol flag cleared", 1'b0, pol_rev_flag_o)
    run_frame(6, 31);
    report_and_stop();
  end
endmodule
bind fsl_line_coding fsl_line_coding_asserts u_fsl_line_coding_asserts (.mclk_i, .rst_b_i,
  .sym_mode_i, .tx_inv_en_i, .pol_inhibit_i, .tx_nib_i, .rx_line_i, .nlp_stb_i,
  .nlp_neg_i, .stat_rd_i, .tx_take_o, .rx_nib_o, .tx_line_o, .inv_sym_flag_o,
  .halt_flag_o, .pol_rev_flag_o, .pol_inv_o);
`default_nettype wire
